// ---- rtl/tmg_consts.vh ----
// Constants for the timer one control and gate block.
// Included by tmg_timer.v; definitions only.
`ifndef TMG_CONSTS_VH
`define TMG_CONSTS_VH
`define TMG_A_CTRL 8'h00
`define TMG_A_GATE 8'h04
`define TMG_A_CLO 8'h08
`define TMG_A_CHI 8'h0C
`define TMG_A_STAT 8'h10
`define TMG_A_MASK 8'h14
`define TMG_CS_HI 7
`define TMG_CS_LO 6
`define TMG_PS_HI 5
`define TMG_PS_LO 4
`define TMG_OSCEN 3
`define TMG_NSYNC 2
`define TMG_ON 0
`define TMG_GE 7
`define TMG_GPOL 6
`define TMG_GTM 5
`define TMG_GSPM 4
`define TMG_GGO 3
`define TMG_GVAL 2
`define TMG_GSS_HI 1
`define TMG_GSS_LO 0
`define TMG_CTRL_WMASK 8'hFD
`define TMG_GATE_WMASK 8'hF3
`define TMG_CS_INSTR 2'h0
`define TMG_CS_SYS 2'h1
`define TMG_CS_PIN 2'h2
`define TMG_CS_CAP 2'h3
`define TMG_GS_PIN 2'h0
`define TMG_GS_T0 2'h1
`define TMG_GS_C1 2'h2
`define TMG_GS_C2 2'h3
`define TMG_INSTR_DIV 2'h3
`define TMG_ST_OVF 0
`define TMG_ST_GATE 1
`define TMG_CNT_MAX 16'hFFFF
`define TMG_ZERO8 8'h00
`define TMG_ZERO16 16'h0000
`endif

// ---- rtl/tmg_timer.v ----
// Timer one: 16-bit counter with clock select, prescaler and gate logic.
// Assumes a single AHB-Lite master and asynchronous external pin inputs.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "tmg_consts.vh"

// How it works
// - Source code selects instruction, system, pin-or-crystal or cap oscillator.
// - Code 10 counts pin rising edges, or crystal when oscillator enabled.
// - Prescale field divides the selected clock by 1, 2, 4 or 8.
// - Control bit 3 switches the dedicated oscillator on or off.
// - For external sources sync-disable chooses synchronised or raw edges.
// - Timer-on enables counting; clearing it stops and clears toggle flop.
// - While on, gate enable makes counting depend on the gate.
// - Polarity bit chooses active-high or active-low gate.
// - Toggle mode flips a flop per gate rising edge, else held clear.
// - Single-pulse mode bit enables single-pulse gate acquisition.
// - Go/done reads 1 while armed; software sets, hardware clears.
// - Read-only gate level shows current gate regardless of gate enable.
// - Gate source: pin, timer0 overflow, comparator one, comparator two.
// - Writable bits reset to zero; unimplemented control bit 1 reads zero.
// - Armed pulse counts while gate active; go/done clears at trailing edge.
// - Falling edge of gate level sets gate event flag.
// - Counter wraps FFFF to 0000 and sets overflow flag.
module tmg_timer
(
   input wire mclk,
   input wire rst,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hsel,
   input wire hready,
   input wire [31:0] hwdata,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire external_count_pin,
   input wire crystal_clk,
   input wire cap_sense_oscillator,
   input wire gate_pin,
   input wire timer0_overflow,
   input wire cmp_one_synced_out,
   input wire cmp_two_synced_out,
   output wire dedicated_osc_enable,
   output wire irq
);

   reg [7:0] ctrl_r;
   reg g_en_r;
   reg g_pol_r;
   reg g_tm_r;
   reg g_spm_r;
   reg [1:0] gss_r;
   reg go_r;
   reg [15:0] cnt_r;
   reg [1:0] stat_r;
   reg [1:0] mask_r;
   reg [31:0] hrdata_r;
   reg wr_pend_r;
   reg [7:0] addr_r;
   reg [1:0] icnt_r;
   reg [2:0] pre_r;
   reg tog_r;
   reg gval_r;
   reg gval_prev_r;
   reg gval_known_r;
   reg [7:0] ctrl_nxt;
   reg [7:0] gate_nxt;
   wire ext_rise;
   wire gsrc_lvl;
   wire gsrc_rise;
   wire cap_rise;

   wire [1:0] cs = ctrl_r[`TMG_CS_HI:`TMG_CS_LO];
   wire [1:0] ps = ctrl_r[`TMG_PS_HI:`TMG_PS_LO];
   wire tmr_on = ctrl_r[`TMG_ON];
   wire nsync = ctrl_r[`TMG_NSYNC];
   wire g_en = g_en_r;
   wire g_pol = g_pol_r;
   wire g_tm = g_tm_r;
   wire g_spm = g_spm_r;
   wire [1:0] gss = gss_r;

   // Bus address phase capture; no wait states.
   wire take = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   assign dedicated_osc_enable = ctrl_r[`TMG_OSCEN];

   // The raw external level feeds the unsynchronised path. Sampling it
   // directly on mclk is the closest a single-clock design can get.
   reg ext_raw;
   always @*
   begin
      ext_raw = ctrl_r[`TMG_OSCEN] ? crystal_clk : external_count_pin;
   end

   reg src_sel;
   always @*
   begin
      case (gss)
         `TMG_GS_PIN: src_sel = gate_pin;
         `TMG_GS_T0: src_sel = timer0_overflow;
         `TMG_GS_C1: src_sel = cmp_one_synced_out;
         `TMG_GS_C2: src_sel = cmp_two_synced_out;
         default: src_sel = gate_pin;
      endcase
   end

   // External count source; sync-disable bypasses the agreement filter.
   tmg_sync3 tmg_sync3_ext_inst
   (
      .clk(mclk),
      .rst(rst),
      .bypass(nsync),
      .din(ext_raw),
      .lvl(),
      .rise(ext_rise)
   );

   // Gate source; always filtered so a slow edge cannot toggle twice.
   tmg_sync3 tmg_sync3_gate_inst
   (
      .clk(mclk),
      .rst(rst),
      .bypass(1'b0),
      .din(src_sel),
      .lvl(gsrc_lvl),
      .rise(gsrc_rise)
   );

   // Cap oscillator shares the external sync-disable choice.
   tmg_sync3 tmg_sync3_cap_inst
   (
      .clk(mclk),
      .rst(rst),
      .bypass(nsync),
      .din(cap_sense_oscillator),
      .lvl(),
      .rise(cap_rise)
   );

   reg clk_tick;
   always @*
   begin
      case (cs)
         `TMG_CS_INSTR: clk_tick = (icnt_r == `TMG_INSTR_DIV);
         `TMG_CS_SYS: clk_tick = 1'b1;
         `TMG_CS_PIN: clk_tick = ext_rise;
         `TMG_CS_CAP: clk_tick = cap_rise;
         default: clk_tick = 1'b0;
      endcase
   end

   reg pre_tick;
   always @*
   begin
      case (ps)
         2'h0: pre_tick = clk_tick;
         2'h1: pre_tick = clk_tick & (pre_r[0] == 1'b1);
         2'h2: pre_tick = clk_tick & (pre_r[1:0] == 2'h3);
         default: pre_tick = clk_tick & (pre_r == 3'h7);
      endcase
   end

   // Gate chain: toggle flop, polarity, then single-pulse qualification.
   wire tog_in = g_tm ? tog_r : gsrc_lvl;
   wire g_lvl = g_pol ? tog_in : ~tog_in;
   wire g_active = g_spm ? (g_lvl & go_r) : g_lvl;
   wire count_ok = tmr_on & (~g_en | g_active);
   wire inc = pre_tick & count_ok;
   wire ovf = inc & (cnt_r == `TMG_CNT_MAX);
   wire g_fall = gval_known_r & gval_prev_r & ~gval_r;
   wire pulse_end = g_spm & go_r & gval_r & ~g_lvl;

   wire w_ctrl = wr_pend_r & (addr_r == `TMG_A_CTRL);
   wire w_gate = wr_pend_r & (addr_r == `TMG_A_GATE);
   wire w_clo = wr_pend_r & (addr_r == `TMG_A_CLO);
   wire w_chi = wr_pend_r & (addr_r == `TMG_A_CHI);
   wire w_mask = wr_pend_r & (addr_r == `TMG_A_MASK);
   wire r_stat = take & ~hwrite & (haddr[7:0] == `TMG_A_STAT);

   always @*
   begin
      ctrl_nxt = hwdata[7:0] & `TMG_CTRL_WMASK;
      gate_nxt = hwdata[7:0] & `TMG_GATE_WMASK;
   end

   reg [31:0] rd_val;
   always @*
   begin
      rd_val = 32'h0000_0000;
      case (haddr[7:0])
         `TMG_A_CTRL: rd_val[7:0] = ctrl_r;
         `TMG_A_GATE: rd_val[7:0] = {g_en, g_pol, g_tm, g_spm, go_r,
            gval_r, gss};
         `TMG_A_CLO: rd_val[7:0] = cnt_r[7:0];
         `TMG_A_CHI: rd_val[7:0] = cnt_r[15:8];
         `TMG_A_STAT: rd_val[1:0] = stat_r;
         `TMG_A_MASK: rd_val[1:0] = mask_r;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   assign irq = |(stat_r & mask_r);

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= `TMG_ZERO8;
         g_en_r <= 1'b0;
         g_pol_r <= 1'b0;
         g_tm_r <= 1'b0;
         g_spm_r <= 1'b0;
         gss_r <= 2'h0;
         go_r <= 1'b0;
         cnt_r <= `TMG_ZERO16;
         stat_r <= 2'h0;
         mask_r <= 2'h0;
         hrdata_r <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         addr_r <= `TMG_ZERO8;
         icnt_r <= 2'h0;
         pre_r <= 3'h0;
         tog_r <= 1'b0;
         gval_r <= 1'b0;
         gval_prev_r <= 1'b0;
         gval_known_r <= 1'b0;
      end
      else
      begin
         wr_pend_r <= take & hwrite;
         if (take)
            addr_r <= haddr[7:0];
         if (take & ~hwrite)
            hrdata_r <= rd_val;
         // The instruction clock runs free, so its phase is not tied to
         // the moment software switches the timer on.
         icnt_r <= icnt_r + 2'h1;
         // The prescaler advances on every source edge, not only on the
         // edges it lets through, or a divide above one would never fire.
         if (~tmr_on)
            pre_r <= 3'h0;
         else if (clk_tick)
            pre_r <= pre_r + 3'h1;
         if (w_ctrl)
            ctrl_r <= ctrl_nxt;
         if (w_gate)
         begin
            g_en_r <= gate_nxt[`TMG_GE];
            g_pol_r <= gate_nxt[`TMG_GPOL];
            g_tm_r <= gate_nxt[`TMG_GTM];
            g_spm_r <= gate_nxt[`TMG_GSPM];
            gss_r <= gate_nxt[`TMG_GSS_HI:`TMG_GSS_LO];
         end
         if (w_mask)
            mask_r <= hwdata[1:0];
         // Toggle flop is held clear when the mode is off or timer stops.
         if (~g_tm | ~tmr_on)
            tog_r <= 1'b0;
         else if (gsrc_rise)
            tog_r <= ~tog_r;
         gval_r <= g_lvl;
         gval_prev_r <= gval_r;
         gval_known_r <= 1'b1;
         // Hardware clear at trailing edge; a software set wins if coincident.
         if (w_gate & hwdata[`TMG_GGO] & g_spm)
            go_r <= 1'b1;
         else if (~g_spm | pulse_end)
            go_r <= 1'b0;
         if (w_clo)
            cnt_r[7:0] <= hwdata[7:0];
         else if (w_chi)
            cnt_r[15:8] <= hwdata[7:0];
         else if (inc)
            cnt_r <= cnt_r + 16'h0001;
         // A read clears status, but an event in the same cycle stays set,
         // so software never loses an event that lands on its read.
         if (ovf)
            stat_r[`TMG_ST_OVF] <= 1'b1;
         else if (r_stat)
            stat_r[`TMG_ST_OVF] <= 1'b0;
         if (g_fall)
            stat_r[`TMG_ST_GATE] <= 1'b1;
         else if (r_stat)
            stat_r[`TMG_ST_GATE] <= 1'b0;
      end
   end

endmodule

// Three-stage input synchroniser with an agreement filter and edge output.
module tmg_sync3
(
   input wire clk,
   input wire rst,
   input wire bypass,
   input wire din,
   output wire lvl,
   output wire rise
);

   reg [2:0] stage_r;
   reg prev_r;
   reg lvl_nxt;

   // Unless bypassed, a level only counts once the second and third stages
   // agree, so an input caught mid-transition cannot produce a double edge.
   always @*
   begin
      if (bypass)
         lvl_nxt = stage_r[1];
      else if (stage_r[1] == stage_r[2])
         lvl_nxt = stage_r[1];
      else
         lvl_nxt = prev_r;
   end

   assign lvl = lvl_nxt;
   assign rise = lvl_nxt & ~prev_r;

   // Reset state matches the idle low level, so no false edge follows.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stage_r <= 3'h0;
         prev_r <= 1'b0;
      end
      else
      begin
         stage_r <= {stage_r[1:0], din};
         prev_r <= lvl_nxt;
      end
   end

endmodule

// ---- verification/tmg_timer_assertions.sv ----
// Checker for tmg_timer: bus answer, register and interrupt relations.
// Bound to the design; sees its ports only.
`timescale 1ns/1ps
module tmg_timer_chk
(
   input wire mclk,
   input wire rst,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hsel,
   input wire hready,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire dedicated_osc_enable,
   input wire irq
);
   wire acc = hsel & hready & htrans[1];
   wire rd = acc & ~hwrite;
   wire [7:0] ad = haddr[7:0];
   reg [7:0] ctl_r, wa_r;
   reg [1:0] msk_r;
   reg wv_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Mirror of written values, taken in the data phase as the slave does.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         {ctl_r, wa_r, msk_r, wv_r} <= 19'h0;
      else
      begin
         wv_r <= acc & hwrite;
         wa_r <= ad;
         if (wv_r && wa_r == 8'h00)
            ctl_r <= hwdata[7:0] & 8'hFD;
         if (wv_r && wa_r == 8'h14)
            msk_r <= hwdata[1:0];
      end
   end
   hready_high_a: assert property (hreadyout)
      else $error("slave inserted a wait state");
   resp_okay_a: assert property (!hresp)
      else $error("slave answered with an error");
   reset_clear_a: assert property (
      $fell(rst) |-> hrdata == 32'h0 && !irq && !dedicated_osc_enable)
      else $error("outputs not clear after reset");
   osc_follow_a: assert property (
      dedicated_osc_enable == ctl_r[3])
      else $error("oscillator enable differs from control bit");
   ctrl_read_a: assert property (
      rd && ad == 8'h00 |=> hrdata == {24'h0, ctl_r})
      else $error("control read differs from written value");
   unmapped_zero_a: assert property (
      rd && ad > 8'h14 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   mask_quiet_a: assert property (msk_r == 2'h0 |-> !irq)
      else $error("interrupt raised while masked");
   status_read_a: assert property (
      rd && ad == 8'h10 |=> hrdata[31:2] == 30'h0)
      else $error("status read shows stray bits");
   cover property (rd && ad == 8'h10 ##1 hrdata[0]);
   cover property (rd && ad == 8'h10 ##1 hrdata[1]);
   cover property ($rose(irq));
endmodule
bind tmg_timer tmg_timer_chk tmg_timer_chk_inst (.mclk(mclk), .rst(rst),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsel(hsel),
   .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
   .dedicated_osc_enable(dedicated_osc_enable));

// ---- verification/tmg_timer_tb_top.sv ----
// Bench for tmg_timer: registers, counting, gate and interrupt.
// Drives the AHB-Lite port and the count and gate pins itself.
`timescale 1ns/1ps
module tmg_timer_tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic tgl = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] seed = 32'h28;
   logic [2:0] csel = 3'h0;
   logic [3:0] gsrc = 4'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, osc, irq;
   logic [7:0] q, v;
   int fail_count = 0;
   int samples_checked = 0;
   int i, j;
   always #2 mclk = ~mclk;
   tmg_timer tmg_timer_inst (.mclk(mclk), .rst(rst), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(hsel),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .external_count_pin(tgl & csel[0]), .crystal_clk(tgl & csel[1]),
      .cap_sense_oscillator(tgl & csel[2]), .gate_pin(gsrc[0]),
      .timer0_overflow(gsrc[1]), .cmp_one_synced_out(gsrc[2]),
      .cmp_two_synced_out(gsrc[3]), .dedicated_osc_enable(osc),
      .irq(irq));
   function automatic logic [31:0] xs(logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      samples_checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // An idle cycle follows each transfer, so a read never meets a write
   // to the same register still landing.
   task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      q = hrdata[7:0];
      @(posedge mclk);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #40000;
      fail_count++;
      stop_test();
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (i = 0; i < 7; i++)
      begin
         xfer(1'b0, 8'(i * 4), 8'h00);
         chk("reset value", q, (i == 1) ? 8'h04 : 8'h00);
      end
      for (i = 0; i < 20; i++)
      begin
         seed = xs(seed);
         v = seed[7:0];
         xfer(1'b1, 8'h00, v);
         xfer(1'b0, 8'h00, 8'h00);
         chk("control", q, v & 8'hFD);
         chk("osc enable", {7'h0, osc}, {7'h0, v[3]});
         xfer(1'b1, 8'h04, seed[15:8] & 8'hE3);
         xfer(1'b0, 8'h04, 8'h00);
         chk("gate control", q & 8'hF3, seed[15:8] & 8'hE3);
      end
      xfer(1'b1, 8'h04, 8'h00);
      $display("registers done");
      for (j = 0; j < 5; j++)
      begin
         xfer(1'b1, 8'h08, 8'h00);
         xfer(1'b1, 8'h0C, 8'h00);
         xfer(1'b1, 8'h00, (j == 4) ? 8'h01 : 8'h41 | 8'(j << 4));
         repeat (64) @(posedge mclk);
         xfer(1'b1, 8'h00, 8'h00);
         xfer(1'b0, 8'h08, 8'h00);
         i = int'(q) - (67 >> (j % 4 + 2 * (j / 4)));
         chk("prescale", 8'(i * i <= 4), 8'h01);
      end
      xfer(1'b1, 8'h14, 8'h01);
      xfer(1'b1, 8'h0C, 8'hFF);
      xfer(1'b1, 8'h08, 8'hF0);
      xfer(1'b1, 8'h00, 8'h41);
      repeat (40) @(posedge mclk);
      xfer(1'b1, 8'h00, 8'h00);
      chk("irq raised", {7'h0, irq}, 8'h01);
      xfer(1'b0, 8'h10, 8'h00);
      chk("overflow flag", q & 8'h01, 8'h01);
      xfer(1'b0, 8'h0C, 8'h00);
      chk("count wrapped", q, 8'h00);
      xfer(1'b0, 8'h10, 8'h00);
      chk("flag cleared", {q[0], irq}, 8'h00);
      $display("counting done");
      for (j = 0; j < 6; j++)
      begin
         csel <= 3'(1 << (j / 2));
         xfer(1'b1, 8'h08, 8'h00);
         v = (j < 2) ? 8'h81 : (j < 4) ? 8'h89 : 8'hC1;
         xfer(1'b1, 8'h00, v | 8'((j % 2) << 2));
         repeat (16)
         begin
            repeat (4) @(posedge mclk);
            tgl <= ~tgl;
         end
         repeat (8) @(posedge mclk);
         xfer(1'b1, 8'h00, 8'h00);
         xfer(1'b0, 8'h08, 8'h00);
         chk("pin count", q, 8'h08);
      end
      $display("pins done");
      xfer(1'b1, 8'h14, 8'h02);
      for (j = 0; j < 4; j++)
      begin
         xfer(1'b1, 8'h04, 8'h40 | 8'(j));
         repeat (6) @(posedge mclk);
         xfer(1'b0, 8'h10, 8'h00);
         gsrc <= 4'(1 << j);
         repeat (6) @(posedge mclk);
         xfer(1'b0, 8'h04, 8'h00);
         chk("gate level", q & 8'h04, 8'h04);
         gsrc <= 4'h0;
         repeat (6) @(posedge mclk);
         chk("gate irq", {7'h0, irq}, 8'h01);
      end
      for (j = 0; j < 3; j++)
      begin
         xfer(1'b1, 8'h04, (j == 0) ? 8'hC0 : (j == 1) ? 8'h80 : 8'h40);
         xfer(1'b1, 8'h08, 8'h00);
         xfer(1'b1, 8'h00, 8'h41);
         repeat (20) @(posedge mclk);
         xfer(1'b1, 8'h00, 8'h00);
         xfer(1'b0, 8'h08, 8'h00);
         chk("gated count", 8'(q != 8'h00), 8'(j != 0));
      end
      xfer(1'b1, 8'h04, 8'h50);
      xfer(1'b1, 8'h04, 8'h58);
      xfer(1'b0, 8'h04, 8'h00);
      chk("go armed", q & 8'h08, 8'h08);
      gsrc <= 4'h1;
      repeat (8) @(posedge mclk);
      gsrc <= 4'h0;
      repeat (8) @(posedge mclk);
      xfer(1'b0, 8'h04, 8'h00);
      chk("go done", q & 8'h08, 8'h00);
      $display("gate done");
      stop_test();
   end
endmodule
